// File: rtl/frtic_consts.vh
// Purpose: Constants for the free-running timer with input capture
// Assumes: AHB-Lite register access, 32-bit word per register
// Notes:   Offsets are byte addresses
`ifndef FRTIC_CONSTS_VH
`define FRTIC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FRTIC_OFF_COUNT      12'h000
`define FRTIC_OFF_CTRL       12'h004
`define FRTIC_OFF_CAP_CTRL   12'h008
`define FRTIC_OFF_IRQ_STAT   12'h00C
`define FRTIC_OFF_IRQ_EN     12'h010
`define FRTIC_OFF_IRQ_CLR    12'h014
`define FRTIC_OFF_CAP0       12'h020
`define FRTIC_OFF_CAP1       12'h024
`define FRTIC_OFF_CAP2       12'h028
`define FRTIC_OFF_CAP3       12'h02C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define FRTIC_CTRL_DIV_LSB   0
`define FRTIC_CTRL_STOP_BIT  2
`define FRTIC_CTRL_CLR_BIT   3
`define FRTIC_CTRL_RESET     4'h0

// ----------------------------------------
// Edge select encoding, two bits per pin
// ----------------------------------------
`define FRTIC_EDGE_NONE      2'h0
`define FRTIC_EDGE_RISE      2'h1
`define FRTIC_EDGE_FALL      2'h2
`define FRTIC_EDGE_BOTH      2'h3

// ----------------------------------------
// Interrupt status layout
// ----------------------------------------
`define FRTIC_IRQ_OVF_BIT    0
`define FRTIC_IRQ_CAP_LSB    1

// ----------------------------------------
// Reset value and interrupt number
// ----------------------------------------
`define FRTIC_COUNT_RESET    16'h0000
`define FRTIC_IRQ_NUMBER     8'h13

`endif

// File: rtl/frtic_prescaler.v
// Purpose: Divides the machine clock into a one-cycle count tick
// Assumes: Single clock domain
// Notes:   Ratios are 1, 2, 4 and 8 with the default shift step
`timescale 1ns/1ps
`default_nettype none

module frtic_prescaler #(
    parameter STEP = 1
) (
    input  wire       clk_sys_in,
    input  wire       rst_b_in,
    input  wire [1:0] div_sel_in,
    input  wire       run_in,
    output reg        tick_out
);

    reg  [7:0] div_cnt_reg;
    wire [7:0] div_last;

    // Terminal count for ratio two to the power of sel times step
    assign div_last = (8'h01 << (div_sel_in * STEP)) - 8'h01;

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_cnt_reg <= 8'h00;
            tick_out    <= 1'b0;
        end else if (!run_in) begin
            // Halting restarts the division so a resume is clean
            div_cnt_reg <= 8'h00;
            tick_out    <= 1'b0;
        end else if (div_cnt_reg >= div_last) begin
            div_cnt_reg <= 8'h00;
            tick_out    <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
            tick_out    <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: rtl/frtic_capture_pin.v
// Purpose: One capture input with synchroniser, edge select and latch
// Assumes: Pin is asynchronous to the machine clock
// Notes:   Two flops of delay before an edge is seen
`timescale 1ns/1ps
`default_nettype none

`include "frtic_consts.vh"

module frtic_capture_pin #(
    parameter WIDTH = 16
) (
    input  wire             clk_sys_in,
    input  wire             rst_b_in,
    input  wire             pin_in,
    input  wire [1:0]       edge_sel_in,
    input  wire [WIDTH-1:0] time_base_in,
    output reg  [WIDTH-1:0] cap_value_out,
    output wire             cap_event_out
);

    reg  sync1_reg;
    reg  sync2_reg;
    reg  prev_reg;
    wire rise;
    wire fall;

    // ----------------------------------------
    // Synchroniser and edge detection
    // ----------------------------------------
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= pin_in; // RULE12
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;
    assign cap_event_out = (edge_sel_in[0] & rise) | // RULE7
                           (edge_sel_in[1] & fall);

    // ----------------------------------------
    // Capture latch, held until next event
    // ----------------------------------------
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cap_value_out <= {WIDTH{1'b0}};
        end else if (cap_event_out) begin
            cap_value_out <= time_base_in; // RULE6 RULE12
        end
    end

endmodule

`default_nettype wire

// File: rtl/frtic_top.v
// Purpose: Free-running 16-bit timer with four capture inputs
// Assumes: AHB-Lite slave, single word transfers, 40 MHz machine clock
// Notes:   Zero wait states; response always OKAY
`timescale 1ns/1ps
`default_nettype none

`include "frtic_consts.vh"

// Notes on behaviour
// RULE1 - 16-bit up counter advances per prescaler tick; four divide ratios.
// RULE2 - Counter overflow raises an interrupt when enabled.
// RULE3 - Interrupt request also serves as hardware transfer service trigger.
// RULE4 - Counter clears on reset and on software writing the clear bit.
// RULE5 - Live counter value feeds every capture unit as time base.
// RULE6 - Qualifying edge stores the counter value in that pin's register.
// RULE7 - Each input selects rising, falling or both edges.
// RULE8 - A qualifying capture edge can raise an interrupt.
// RULE9 - Two units of two pins, four data registers, four events; the code has four capture units of one pin each.
// RULE10 - Counter reads live value; writes load only while halted.
// RULE11 - Counter interrupt goes out on request number 19.
// RULE12 - Inputs synchronised first; capture held until next qualifying edge.
module frtic_top #(
    parameter WIDTH = 16,
    parameter PINS  = 4
) (
    input  wire            clk_sys_in,
    input  wire            rst_b_in,
    input  wire            hsel_in,
    input  wire [31:0]     haddr_in,
    input  wire [1:0]      htrans_in,
    input  wire            hwrite_in,
    input  wire [2:0]      hsize_in,
    input  wire [31:0]     hwdata_in,
    input  wire            hready_in,
    output reg  [31:0]     hrdata_out,
    output wire            hreadyout_out,
    output wire            hresp_out,
    input  wire [PINS-1:0] cap_pin_in,
    output wire            irq_out,
    output wire            hw_xfer_req_out,
    output wire [7:0]      irq_number_out
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg  [WIDTH-1:0]    count_reg;
    reg  [1:0]          div_sel_reg;
    reg                 stop_reg;
    reg  [2*PINS-1:0]   edge_sel_reg;
    reg  [PINS:0]       irq_stat_reg;
    reg  [PINS:0]       irq_en_reg;
    reg                 wr_pend_reg;
    reg  [11:0]         wr_addr_reg;
    wire                tick;
    wire [PINS-1:0]     cap_event;
    wire [WIDTH*PINS-1:0] cap_value;
    wire                addr_phase;
    wire                wr_now;
    wire [PINS:0]       irq_set;
    wire [PINS:0]       irq_clr;
    wire                overflow;
    wire                sw_clear;
    wire                sw_load;

    // Register hit test used by every write path
    function hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign addr_phase    = hsel_in & htrans_in[1] & hready_in;
    assign wr_now        = wr_pend_reg;

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= addr_phase & hwrite_in;
            wr_addr_reg <= haddr_in[11:0];
        end
    end

    // Read data registered at the address phase; counter seen live
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_phase & ~hwrite_in) begin
            case (haddr_in[11:0])
                `FRTIC_OFF_COUNT:
                    hrdata_out <= {16'h0000, count_reg}; // RULE10
                `FRTIC_OFF_CTRL:
                    hrdata_out <= {28'h000_0000, 1'b0, stop_reg,
                                   div_sel_reg};
                `FRTIC_OFF_CAP_CTRL:
                    hrdata_out <= {24'h00_0000, edge_sel_reg};
                `FRTIC_OFF_IRQ_STAT:
                    hrdata_out <= {27'h000_0000, irq_stat_reg};
                `FRTIC_OFF_IRQ_EN:
                    hrdata_out <= {27'h000_0000, irq_en_reg};
                `FRTIC_OFF_CAP0:
                    hrdata_out <= {16'h0000, cap_value[15:0]};
                `FRTIC_OFF_CAP1:
                    hrdata_out <= {16'h0000, cap_value[31:16]};
                `FRTIC_OFF_CAP2:
                    hrdata_out <= {16'h0000, cap_value[47:32]};
                `FRTIC_OFF_CAP3:
                    hrdata_out <= {16'h0000, cap_value[63:48]};
                default:
                    hrdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_sel_reg  <= 2'h0;
            stop_reg     <= 1'b0;
            edge_sel_reg <= {PINS{`FRTIC_EDGE_NONE}};
            irq_en_reg   <= {(PINS+1){1'b0}};
        end else if (wr_now) begin
            if (hit(wr_addr_reg, `FRTIC_OFF_CTRL)) begin
                div_sel_reg <= hwdata_in[`FRTIC_CTRL_DIV_LSB +: 2]; // RULE1
                stop_reg    <= hwdata_in[`FRTIC_CTRL_STOP_BIT];
            end
            if (hit(wr_addr_reg, `FRTIC_OFF_CAP_CTRL)) begin
                edge_sel_reg <= hwdata_in[2*PINS-1:0]; // RULE7
            end
            if (hit(wr_addr_reg, `FRTIC_OFF_IRQ_EN)) begin
                irq_en_reg <= hwdata_in[PINS:0];
            end
        end
    end

    // ----------------------------------------
    // Prescaler and free-running counter
    // ----------------------------------------
    frtic_prescaler #(
        .STEP (1)
    ) u_prescaler (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .div_sel_in (div_sel_reg),
        .run_in     (~stop_reg),
        .tick_out   (tick)
    );

    assign sw_clear = wr_now & hit(wr_addr_reg, `FRTIC_OFF_CTRL) &
                      hwdata_in[`FRTIC_CTRL_CLR_BIT];
    assign sw_load  = wr_now & hit(wr_addr_reg, `FRTIC_OFF_COUNT) &
                      stop_reg;
    assign overflow = tick & ~sw_clear & ~sw_load &
                      (count_reg == {WIDTH{1'b1}});

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg <= `FRTIC_COUNT_RESET; // RULE4
        end else if (sw_clear) begin
            count_reg <= `FRTIC_COUNT_RESET; // RULE4
        end else if (sw_load) begin
            // Loading a running counter would race the tick
            count_reg <= hwdata_in[WIDTH-1:0]; // RULE10
        end else if (tick) begin
            count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1}; // RULE1
        end
    end

    // ----------------------------------------
    // Capture units, one pin each
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_cap
            frtic_capture_pin #(
                .WIDTH (WIDTH)
            ) u_pin (
                .clk_sys_in    (clk_sys_in),
                .rst_b_in      (rst_b_in),
                .pin_in        (cap_pin_in[g]), // RULE9
                .edge_sel_in   (edge_sel_reg[2*g +: 2]),
                .time_base_in  (count_reg), // RULE5
                .cap_value_out (cap_value[WIDTH*g +: WIDTH]),
                .cap_event_out (cap_event[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Interrupt status, set wins over clear
    // ----------------------------------------
    assign irq_set = {cap_event, overflow}; // RULE2 RULE8
    assign irq_clr = (wr_now & hit(wr_addr_reg, `FRTIC_OFF_IRQ_CLR)) ?
                     hwdata_in[PINS:0] : {(PINS+1){1'b0}};

    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_stat_reg <= {(PINS+1){1'b0}};
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end

    assign irq_out         = |(irq_stat_reg & irq_en_reg); // RULE2 RULE8
    assign hw_xfer_req_out = irq_out; // RULE3
    assign irq_number_out  = `FRTIC_IRQ_NUMBER; // RULE11

endmodule

`default_nettype wire

// File: bench/frtic_pin_src.sv
// Purpose: Outside sources driving the four capture pins
// Assumes: Sources are unrelated to the machine clock
// Notes:   Levels land 7 ns after the request, off the clock grid
`timescale 1ns/1ps
`default_nettype none
module frtic_pin_src (
    input  wire logic [3:0] level_in,
    output var  logic [3:0] pins_out
);
    // ----------------
    // Pin drivers
    // ----------------
    initial pins_out = 4'h0;
    // Off-grid edges exercise the synchroniser, not just the edge flop
    always @(level_in) pins_out <= #7 level_in;
endmodule
`default_nettype wire

// File: bench/frtic_monitor.sv
// Purpose: Port checks for the capture timer
// Assumes: One clock, zero wait bus slave
// Notes:   Read data is checked one edge after its address phase
`timescale 1ns/1ps
`default_nettype none
module frtic_monitor (
    input wire logic        clk_sys_in,
    input wire logic        rst_b_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        irq_out,
    input wire logic        hw_xfer_req_out,
    input wire logic [7:0]  irq_number_out
);
    // ----------------
    // Checks
    // ----------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    wire logic        rd_take = hsel_in & htrans_in[1] & ~hwrite_in;
    wire logic        wr_take = hsel_in & htrans_in[1] & hwrite_in;
    wire logic [11:0] a       = haddr_in[11:0];
    a_bus_okay: assert property (
        !hresp_out && hreadyout_out) else $error("bus not okay");
    a_xfer_mirror: assert property (
        hw_xfer_req_out == irq_out) else $error("xfer req differs");
    a_irq_number: assert property (
        irq_number_out == 8'h13) else $error("bad irq number");
    a_unmapped_zero: assert property (
        rd_take && a == 12'h030 |=> hrdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_stands: assert property (
        !rd_take |=> $stable(hrdata_out)) else $error("read data moved");
    a_clear_reads0: assert property (
        rd_take && a == 12'h004 |=> hrdata_out[31:3] == 29'h0)
        else $error("ctrl upper bits not zero");
    a_count_width: assert property (
        rd_take && a == 12'h000 |=> hrdata_out[31:16] == 16'h0)
        else $error("count wider than 16 bits");
    a_irq_masked: assert property (
        wr_take && a == 12'h010 ##1 hwdata_in[4:0] == 5'h0 |=> !irq_out)
        else $error("irq with all enables off");
    c_irq_rise: cover property ($rose(irq_out));
    c_unmapped: cover property (rd_take && a == 12'h030);
    c_mask_off: cover property (wr_take && a == 12'h010);
endmodule
bind frtic_top frtic_monitor u_mon (.clk_sys_in, .rst_b_in, .hsel_in,
    .haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hrdata_out,
    .hreadyout_out, .hresp_out, .irq_out, .hw_xfer_req_out,
    .irq_number_out);
`default_nettype wire

// File: bench/frtic_top_tb.sv
// Purpose: Self-checking bench for the capture timer
// Assumes: Master holds each bus phase until hready
// Notes:   Counter is halted whenever a capture value is compared after the reset-value read sweep
`timescale 1ns/1ps
`default_nettype none
module frtic_top_tb;
    logic        clk_sys_in;
    logic        rst_b_in;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [3:0]  pin_lvl;
    logic [31:0] rd;
    logic [31:0] c1;
    wire  [31:0] hrdata;
    wire         hready;
    wire         irq;
    wire  [3:0]  pins;
    int          n_fail;
    int          total_checks;
    int          cyc;
    // Row: edge mode [3:2], capture on rise [1], on fall [0]
    logic [3:0]  rows [4];
    // ----------------
    // Design and sources
    // ----------------
    frtic_pin_src src (.level_in(pin_lvl), .pins_out(pins));
    frtic_top dut (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .cap_pin_in(pins), .irq_out(irq), .hw_xfer_req_out(),
        .irq_number_out());
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk_sys_in);
        while (hready !== 1'b1) @(posedge clk_sys_in);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys_in);
        while (hready !== 1'b1) @(posedge clk_sys_in);
        rd = hrdata;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t word %h, expected %h", $time, got, exp);
        end
    endtask
    // Waits one edge so a register written just before has landed
    task automatic chk_i(input logic exp);
        @(posedge clk_sys_in);
        total_checks++;
        if (irq !== exp) begin
            n_fail++;
            $display("BAD %0t irq %b, expected %b", $time, irq, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            final_report();
        end
    end
    // ----------------
    // Sequence
    // ----------------
    initial begin
        rst_b_in = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pin_lvl = 4'h0;
        n_fail = 0;
        total_checks = 0;
        cyc = 0;
        rows = '{4'h0, 4'h6, 4'h9, 4'hF};
        repeat (3) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int i = 1; i < 13; i++) begin
            bus(1'b0, 12'(4 * i), 32'h0);
            chk_w(rd, 32'h0);
        end
        bus(1'b0, 12'h000, 32'h0);
        chk_w(rd & 32'hFF00, 32'h0);
        bus(1'b1, 12'h004, 32'h0000_000C);
        bus(1'b0, 12'h000, 32'h0);
        chk_w(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 12'h004, 32'(i));
            repeat (16) @(posedge clk_sys_in);
            bus(1'b0, 12'h000, 32'h0);
            c1 = rd;
            repeat (62) @(posedge clk_sys_in);
            bus(1'b0, 12'h000, 32'h0);
            chk_w((rd - c1) & 32'hFFFF, 32'h40 >> i);
        end
        bus(1'b1, 12'h004, 32'h0000_000B);
        bus(1'b1, 12'h000, 32'h0000_5555);
        bus(1'b1, 12'h004, 32'h0000_0004);
        bus(1'b0, 12'h000, 32'h0);
        chk_w(rd & 32'hFFF0, 32'h0);
        bus(1'b1, 12'h000, 32'h0000_FFFE);
        bus(1'b0, 12'h000, 32'h0);
        chk_w(rd, 32'h0000_FFFE);
        bus(1'b1, 12'h010, 32'h1);
        chk_i(1'b0);
        bus(1'b1, 12'h004, 32'h0);
        repeat (4) @(posedge clk_sys_in);
        bus(1'b1, 12'h004, 32'h4);
        bus(1'b0, 12'h00C, 32'h0);
        chk_w(rd, 32'h1);
        chk_i(1'b1);
        bus(1'b0, 12'h000, 32'h0);
        chk_w(rd & 32'hFFF0, 32'h0);
        bus(1'b1, 12'h010, 32'h0);
        chk_i(1'b0);
        bus(1'b1, 12'h014, 32'h1);
        bus(1'b0, 12'h00C, 32'h0);
        chk_w(rd, 32'h0);
        bus(1'b1, 12'h010, 32'h1E);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 12'h000, 32'h1230 + i);
            bus(1'b1, 12'h008, 32'(rows[i][3:2]) << (2 * i));
            pin_lvl[i] <= 1'b1;
            repeat (8) @(posedge clk_sys_in);
            bus(1'b0, 12'h00C, 32'h0);
            chk_w((rd >> (i + 1)) & 32'h1, 32'(rows[i][1]));
            chk_i(rows[i][1]);
            bus(1'b1, 12'h014, 32'h1E);
            pin_lvl[i] <= 1'b0;
            repeat (8) @(posedge clk_sys_in);
            bus(1'b0, 12'h00C, 32'h0);
            chk_w((rd >> (i + 1)) & 32'h1, 32'(rows[i][0]));
            bus(1'b1, 12'h014, 32'h1E);
            bus(1'b0, 12'h020 + 12'(4 * i), 32'h0);
            chk_w(rd, (rows[i][1:0] != 2'h0) ? 32'h1230 + i : 32'h0);
        end
        bus(1'b1, 12'h000, 32'h7777);
        bus(1'b0, 12'h024, 32'h0);
        chk_w(rd, 32'h1231);
        bus(1'b1, 12'h020, 32'hFFFF);
        bus(1'b0, 12'h020, 32'h0);
        chk_w(rd, 32'h0);
        pin_lvl[3] <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        chk_i(1'b1);
        rst_b_in <= 1'b0;
        @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        chk_i(1'b0);
        bus(1'b0, 12'h010, 32'h0);
        chk_w(rd, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
